// ---- hw/slr_pkg.sv ----
// Shared constants and types for the stroke limit signal router
`default_nettype none
package slr_pkg;

	// ***************************************************************
	// Setting encodings
	// ***************************************************************
	localparam logic SRC_LOCAL = 1'h0; // Limits from local pins (default)
	localparam logic SRC_CTRL = 1'h1; // Limits from controller flags
	localparam logic DIR_CCW_UP = 1'h0; // CCW rotation raises the address
	localparam logic DIR_CW_UP = 1'h1; // CW rotation raises the address

	// ***************************************************************
	// Reset values
	// ***************************************************************
	localparam logic RST_LIMIT = 1'h1; // Limits applied until inputs settle
	localparam logic RST_WARN = 1'h0; // No warning after reset

	// ***************************************************************
	// Operating modes of the drive
	// ***************************************************************
	typedef enum logic [1:0] {
		SLR_MODE_POS,
		SLR_MODE_VEL,
		SLR_MODE_TRQ
	} slr_mode_t;

endpackage
`default_nettype wire

// ---- hw/slr_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
// ***************************************************************
// Three-stage pin synchroniser; output moves when stages 2 and 3 agree
// ***************************************************************
module slr_sync (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pin_in,
	output logic level_q
);
	logic s1_q; // First stage, read only by s2_q
	logic s2_q; // Second stage
	logic s3_q; // Third stage

	// Shift chain; reset to open contact so the limit stays applied
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= 1'h0;
			s2_q <= 1'h0;
			s3_q <= 1'h0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a new level only once two stages agree
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			level_q <= 1'h0;
		end else if (s2_q == s3_q) begin
			level_q <= s3_q;
		end
	end
endmodule
`default_nettype wire

// ---- hw/slr_router.sv ----
`timescale 1ns/1ns
`default_nettype none
// Function
// - Upper limit blocks address-increasing motion
// - Lower limit blocks address-decreasing motion
// - Forward stroke end blocks CCW rotation
// - Reverse stroke end blocks CW rotation
// - Source setting 0 uses local pins
// - Source setting 1 uses controller flags
// - Direction 0: forward to upper, reverse lower
// - Direction 1: reverse to upper, forward lower
// - Automatic-on makes stroke ends always on
// - Stroke-end inputs active low, normally closed
// - Active limit raises warning and stops motor
// - Ignore limits in torque, except pole detection
module slr_router (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic forward_stroke_end_n, // Local pin, on = closed = released
	input wire logic reverse_stroke_end_n, // Local pin, on = closed = released
	input wire logic ctrl_upper_limit, // Controller flag, high = limit applied
	input wire logic ctrl_lower_limit, // Controller flag, high = limit applied
	input wire logic sensor_source_setting, // 0 local pins, 1 controller
	input wire logic travel_direction_setting, // 0 CCW up, 1 CW up
	input wire logic auto_on_setting, // Stroke ends forced on
	input wire slr_pkg::slr_mode_t ctrl_mode, // Present control mode
	input wire logic pole_detect_active, // Linear motor pole detection running
	output logic upper_limit_flag, // Reported upper limit
	output logic lower_limit_flag, // Reported lower limit
	output logic block_ccw, // Inhibit CCW rotation
	output logic block_cw, // Inhibit CW rotation
	output logic block_addr_up, // Inhibit address-increasing motion
	output logic block_addr_down, // Inhibit address-decreasing motion
	output logic warn_forward, // Warning: forward stroke end detected
	output logic warn_reverse, // Warning: reverse stroke end detected
	output logic warn_upper, // Warning: controller upper limit detected
	output logic warn_lower, // Warning: controller lower limit detected
	output logic stop_req // Stop motor by configured method
);

	// ***************************************************************
	// Input conditioning
	// ***************************************************************
	logic fwd_pin_q; // Synchronised forward pin level
	logic rev_pin_q; // Synchronised reverse pin level

	slr_sync u_sync_fwd (
		.clk(clk),
		.rst_b(rst_b),
		.pin_in(forward_stroke_end_n),
		.level_q(fwd_pin_q)
	);

	slr_sync u_sync_rev (
		.clk(clk),
		.rst_b(rst_b),
		.pin_in(reverse_stroke_end_n),
		.level_q(rev_pin_q)
	);

	// ***************************************************************
	// Combinational limit mapping
	// ***************************************************************
	logic limits_on; // Stroke limits honoured in this mode
	logic fwd_act; // Forward limit applied (rotation frame)
	logic rev_act; // Reverse limit applied (rotation frame)
	logic up_act; // Upper limit applied (address frame)
	logic dn_act; // Lower limit applied (address frame)
	logic ccw_d;
	logic cw_d;
	logic up_d;
	logic dn_d;

	// ***************************************************************
	// Setting decoders
	// ***************************************************************
	// True while the local pins are the limit source
	function automatic logic src_is_local(input logic src);
		return src == slr_pkg::SRC_LOCAL;
	endfunction

	// True while CCW rotation raises the positioning address
	function automatic logic dir_ccw_up(input logic dir);
		return dir == slr_pkg::DIR_CCW_UP;
	endfunction

	// Maps between rotation and address frames
	always_comb begin
		// Torque mode ignores limits except while pole detection runs
		limits_on = (ctrl_mode != slr_pkg::SLR_MODE_TRQ) || pole_detect_active;
		if (src_is_local(sensor_source_setting)) begin
			// Open contact applies the limit; auto-on forces closed
			fwd_act = !fwd_pin_q && !auto_on_setting;
			rev_act = !rev_pin_q && !auto_on_setting;
			if (dir_ccw_up(travel_direction_setting)) begin
				up_act = fwd_act;
				dn_act = rev_act;
			end else begin
				up_act = rev_act;
				dn_act = fwd_act;
			end
		end else begin
			// Controller flags; local pins play no part
			up_act = ctrl_upper_limit;
			dn_act = ctrl_lower_limit;
			if (dir_ccw_up(travel_direction_setting)) begin
				fwd_act = up_act;
				rev_act = dn_act;
			end else begin
				fwd_act = dn_act;
				rev_act = up_act;
			end
		end
		ccw_d = limits_on && fwd_act;
		cw_d = limits_on && rev_act;
		up_d = limits_on && up_act;
		dn_d = limits_on && dn_act;
	end

	// ***************************************************************
	// Registered outputs
	// ***************************************************************
	// Reported flags follow the mapped address-frame state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			upper_limit_flag <= slr_pkg::RST_LIMIT;
			lower_limit_flag <= slr_pkg::RST_LIMIT;
		end else begin
			upper_limit_flag <= up_act;
			lower_limit_flag <= dn_act;
		end
	end

	// Motion inhibits in both frames
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			block_ccw <= slr_pkg::RST_LIMIT;
			block_cw <= slr_pkg::RST_LIMIT;
			block_addr_up <= slr_pkg::RST_LIMIT;
			block_addr_down <= slr_pkg::RST_LIMIT;
		end else begin
			block_ccw <= ccw_d;
			block_cw <= cw_d;
			block_addr_up <= up_d;
			block_addr_down <= dn_d;
		end
	end

	// Warnings name the detected signal; stop while any is applied
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			warn_forward <= slr_pkg::RST_WARN;
			warn_reverse <= slr_pkg::RST_WARN;
			warn_upper <= slr_pkg::RST_WARN;
			warn_lower <= slr_pkg::RST_WARN;
			stop_req <= slr_pkg::RST_WARN;
		end else begin
			warn_forward <= ccw_d && src_is_local(sensor_source_setting);
			warn_reverse <= cw_d && src_is_local(sensor_source_setting);
			warn_upper <= up_d && !src_is_local(sensor_source_setting);
			warn_lower <= dn_d && !src_is_local(sensor_source_setting);
			stop_req <= ccw_d || cw_d;
		end
	end

	// ***************************************************************
	// Assertions
	// ***************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Controller upper flag stops address-increasing motion
	a_up_block_ctrl: assert property ((sensor_source_setting && ctrl_upper_limit
		&& ctrl_mode != slr_pkg::SLR_MODE_TRQ) |=> block_addr_up)
		else $error("upper flag did not block address increase");
	// Controller lower flag stops address-decreasing motion
	a_dn_block_ctrl: assert property ((sensor_source_setting && ctrl_lower_limit
		&& ctrl_mode != slr_pkg::SLR_MODE_TRQ) |=> block_addr_down)
		else $error("lower flag did not block address decrease");
	// Open forward contact reaches the CCW inhibit through the synchroniser
	a_ccw_from_pin: assert property ((!sensor_source_setting && !auto_on_setting
		&& $stable(sensor_source_setting) && ctrl_mode == slr_pkg::SLR_MODE_POS && !forward_stroke_end_n) [*5]
		|=> block_ccw)
		else $error("open forward pin did not block CCW");
	// Open reverse contact reaches the CW inhibit through the synchroniser
	a_cw_from_pin: assert property ((!sensor_source_setting && !auto_on_setting
		&& ctrl_mode == slr_pkg::SLR_MODE_VEL && !reverse_stroke_end_n) [*5] |=> block_cw)
		else $error("open reverse pin did not block CW");
	// Direction 0 reports the forward contact as the upper limit
	a_dir0_map: assert property ((!sensor_source_setting && !travel_direction_setting)
		|=> upper_limit_flag == (!$past(fwd_pin_q) && !$past(auto_on_setting)))
		else $error("direction 0 mapping wrong");
	// Direction 0 reports the reverse contact as the lower limit
	a_dir0_lower: assert property ((!sensor_source_setting && !travel_direction_setting)
		|=> lower_limit_flag == (!$past(rev_pin_q) && !$past(auto_on_setting)))
		else $error("direction 0 lower mapping wrong");
	// Direction 1 reports the reverse contact as the upper limit
	a_dir1_map: assert property ((!sensor_source_setting && travel_direction_setting)
		|=> upper_limit_flag == (!$past(rev_pin_q) && !$past(auto_on_setting)))
		else $error("direction 1 mapping wrong");
	// Direction 1 reports the forward contact as the lower limit
	a_dir1_lower: assert property ((!sensor_source_setting && travel_direction_setting)
		|=> lower_limit_flag == (!$past(fwd_pin_q) && !$past(auto_on_setting)))
		else $error("direction 1 lower mapping wrong");
	// Automatic-on leaves both rotation directions free
	a_auto_on_free: assert property ((!sensor_source_setting && auto_on_setting)
		|=> !block_ccw && !block_cw && !stop_req)
		else $error("auto-on still limits");
	// Controller source with clear flags ignores the open local pins
	a_ctrl_source: assert property ((sensor_source_setting && !ctrl_upper_limit && !ctrl_lower_limit)
		|=> !block_ccw && !block_cw && !upper_limit_flag)
		else $error("local pins leak into controller source");
	// Torque mode without pole detection honours no limit
	a_torque_ignore: assert property ((ctrl_mode == slr_pkg::SLR_MODE_TRQ && !pole_detect_active)
		|=> !stop_req && !block_addr_up && !block_addr_down)
		else $error("limits honoured in torque mode");
	// Every warning comes with a stop request
	a_warn_stop: assert property ((warn_forward || warn_reverse
		|| warn_upper || warn_lower) |-> stop_req)
		else $error("warning without stop");

	// Main scenarios that the bench is expected to reach
	c_ccw_hit: cover property (!block_ccw ##1 block_ccw);
	c_ctrl_up: cover property (warn_upper);
	c_dir1_up: cover property (travel_direction_setting && upper_limit_flag && !sensor_source_setting);
	c_pole_trq: cover property (ctrl_mode == slr_pkg::SLR_MODE_TRQ && pole_detect_active ##1 stop_req);
	c_auto_free: cover property (auto_on_setting && !forward_stroke_end_n ##1 !block_ccw);
endmodule
`default_nettype wire

// ---- verif/slr_ctrl_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ***************************************************************
// Controller model: sends its own wired limit switches as flags
// ***************************************************************
module slr_ctrl_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic switch_up, // Switch on the address-increasing side
	input wire logic switch_down, // Switch on the address-decreasing side
	output logic ctrl_upper_limit,
	output logic ctrl_lower_limit
);
	// Flags are refreshed every cycle, as a cyclic network frame would
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_upper_limit <= 1'h1; // Limits applied while in reset
			ctrl_lower_limit <= 1'h1;
		end else begin
			ctrl_upper_limit <= switch_up; // Upper switch sent as upper flag
			ctrl_lower_limit <= switch_down; // Lower switch sent as lower flag
		end
	end
endmodule
`default_nettype wire

// ---- verif/slr_router_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(act, exp, msg) begin comparisons++; if ((act) !== (exp)) begin fail_count++; $display("[FAIL] %0t %s", $time, msg); end end
// ***************************************************************
// Self-checking bench for the stroke limit signal router
// ***************************************************************
module slr_router_test;
	logic clk = 1'h0, rst_b = 1'h0; // Clock and reset
	logic fwd_n = 1'h1, rev_n = 1'h1, sw_up = 1'h0, sw_dn = 1'h0; // Pins and switches
	logic src = 1'h0, dir = 1'h0, auto_on = 1'h0, pole = 1'h0; // Settings
	slr_pkg::slr_mode_t mode = slr_pkg::SLR_MODE_POS; // Control mode
	logic c_up, c_dn, up_f, dn_f, b_ccw, b_cw, b_up, b_dn, w_f, w_r, w_u, w_l, stop; // Observed
	logic [10:0] outs;
	int fail_count = 0, comparisons = 0;
	assign outs = {up_f, dn_f, b_ccw, b_cw, b_up, b_dn, w_f, w_r, w_u, w_l, stop};
	always #10 clk = ~clk; // 50 MHz
	slr_ctrl_model ctl (.clk(clk), .rst_b(rst_b), .switch_up(sw_up), .switch_down(sw_dn),
		.ctrl_upper_limit(c_up), .ctrl_lower_limit(c_dn));
	slr_router dut (.clk(clk), .rst_b(rst_b), .forward_stroke_end_n(fwd_n), .reverse_stroke_end_n(rev_n),
		.ctrl_upper_limit(c_up), .ctrl_lower_limit(c_dn), .sensor_source_setting(src),
		.travel_direction_setting(dir), .auto_on_setting(auto_on), .ctrl_mode(mode),
		.pole_detect_active(pole), .upper_limit_flag(up_f), .lower_limit_flag(dn_f), .block_ccw(b_ccw),
		.block_cw(b_cw), .block_addr_up(b_up), .block_addr_down(b_dn), .warn_forward(w_f),
		.warn_reverse(w_r), .warn_upper(w_u), .warn_lower(w_l), .stop_req(stop));
	// Expected outputs worked out from the present stimulus
	function automatic logic [10:0] expect_out();
		logic fl, rl, u, d, cc, cw, en;
		fl = ~auto_on & ~fwd_n; // Open forward contact applies it
		rl = ~auto_on & ~rev_n; // Open reverse contact applies it
		u = src ? sw_up : (dir ? rl : fl); // Upper report by source and direction
		d = src ? sw_dn : (dir ? fl : rl); // Lower report by source and direction
		cc = src ? (dir ? d : u) : fl; // CCW inhibit
		cw = src ? (dir ? u : d) : rl; // CW inhibit
		en = (mode != slr_pkg::SLR_MODE_TRQ) | pole; // Torque mode gating
		return {u, d, {cc, cw, u, d} & {4{en}}, {~src & fl, ~src & rl, src & u, src & d} & {4{en}}, en & (cc | cw)};
	endfunction
	// Drive all inputs at a falling edge and let the longest path settle
	task automatic apply(input logic [9:0] v);
		@(negedge clk);
		{fwd_n, rev_n, sw_up, sw_dn, src, dir, auto_on, pole} = v[9:2];
		mode = slr_pkg::slr_mode_t'(v[1:0]);
		repeat (7) @(negedge clk);
	endtask
	// Reset values, then everything released
	task automatic t_reset();
		`CHK({up_f, dn_f, b_ccw, b_cw, b_up, b_dn}, {6{slr_pkg::RST_LIMIT}}, "limits during reset")
		`CHK({w_f, w_r, w_u, w_l, stop}, {5{slr_pkg::RST_WARN}}, "warnings during reset")
		rst_b = 1'h1;
		apply({2'h3, 8'h00});
		`CHK(outs, 11'h000, "idle after reset")
		$display("test reset done");
	endtask
	// Local pins in both directions, position and velocity modes, controller flags set opposite
	task automatic t_local();
		for (int i = 0; i < 8; i++) begin
			apply({i[0], i[1], ~i[0], ~i[1], 1'h0, i[2], 3'h0, i[0]});
			`CHK(outs, expect_out(), "local pin mapping")
		end
		$display("test local done");
	endtask
	// Controller flags in both directions, local pins open
	task automatic t_ctrl();
		for (int i = 0; i < 8; i++) begin
			apply({2'h0, i[0], i[1], 1'h1, i[2], 4'h1});
			`CHK(outs, expect_out(), "controller flag mapping")
		end
		$display("test ctrl done");
	endtask
	// Automatic-on with both contacts open
	task automatic t_auto();
		for (int i = 0; i < 2; i++) begin
			apply({5'h00, i[0], 1'h1, 3'h0});
			`CHK(outs, 11'h000, "automatic-on still limits")
		end
		$display("test auto done");
	endtask
	// Every mode with and without pole detection, forward contact open
	task automatic t_mode();
		for (int i = 0; i < 6; i++) begin
			apply({6'h10, 1'h0, i[0], 2'(i / 2)});
			`CHK(outs, expect_out(), "mode gating")
		end
		$display("test mode done");
	endtask
	// Verdict and end of run
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		repeat (100000) @(posedge clk);
		fail_count++;
		summarize();
	end
	// Main sequence
	initial begin
		repeat (20) @(negedge clk);
		t_reset();
		t_local();
		t_ctrl();
		t_auto();
		t_mode();
		summarize();
	end
endmodule
`default_nettype wire
